// ===== sim/tb_timer8_compare_waveform_gen.sv
`timescale 1ns/1ns
`default_nettype none
module tb_timer8_compare_waveform_gen;
    // ****************************************************************
    // Signals and bookkeeping
    // ****************************************************************
    logic        clk;         // 20 MHz system clock
    logic        rst_n;       // Synchronous reset, active low
    logic        timer_tick;  // Tick enable to the counter
    logic        psel;        // APB select
    logic        penable;     // APB enable
    logic        pwrite;      // APB direction
    logic [7:0]  paddr;       // APB address
    logic [31:0] pwdata;      // APB write data
    logic [31:0] prdata;      // APB read data
    logic        pready;      // APB ready
    logic        pslverr;     // APB error
    logic        pin_out;     // Pin value from the block
    logic        pin_oe;      // Pin enable from the block
    logic        pin_level;   // Resolved wire level
    logic [31:0] rd;          // Last read word
    logic        slverr_seen; // Error taken with last transfer
    int          err_total;   // Mismatch counter
    int          n_compared;  // Comparison counter
    int          cycles;      // Cycles since start
    localparam logic [31:0] OVF = 32'h0000_0001; // Overflow flag
    localparam logic [31:0] CMP = 32'h0000_0002; // Match flag
    localparam logic [31:0] DIR = 32'h0000_0001; // Pin direction
    localparam logic [31:0] ST  = 32'h0000_0004; // Output state

    tmr_waveform_gen dut_u
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .timer_tick (timer_tick),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .pin_out    (pin_out),
        .pin_oe     (pin_oe)
    );
    tmr_pin_load load_u
    (
        .pin_out   (pin_out),
        .pin_oe    (pin_oe),
        .pin_level (pin_level)
    );

    // Free-running clock
    initial clk = 1'b0;
    always #25 clk = ~clk;

    // Hang guard, far above the roughly 1900 cycles needed
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            results();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp)
        begin
            $display("MISMATCH %0t %s", $time, what);
            err_total++;
        end
    endtask

    // One APB transfer; an edge passes first so psel is never set twice
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] data);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Ends once pready is high; only the hang guard ends a stuck wait
        while (pready !== 1'b1)
            @(posedge clk);
        rd          = prdata;
        slverr_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp,
                          input string what);
        apb(1'b0, addr, 32'h0000_0000);
        check(rd, exp, what);
    endtask

    // Hold the tick enable for n cycles, always ends low
    task automatic tick(input int n);
        repeat (n)
        begin
            timer_tick <= 1'b1;
            @(posedge clk);
        end
        timer_tick <= 1'b0;
    endtask

    function automatic logic [31:0] ctrl(input logic [2:0] cs,
        input logic [1:0] wgm, input logic [1:0] com, input logic frc);
        ctrl = 32'h0000_0000;
        ctrl[tmr_pkg::CTRL_CS_LSB +: 3]  = cs;
        ctrl[tmr_pkg::CTRL_WGM_LSB +: 2] = wgm;
        ctrl[tmr_pkg::CTRL_COM_LSB +: 2] = com;
        ctrl[tmr_pkg::CTRL_FORCE]        = frc;
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        rd_chk(tmr_pkg::OFF_CTRL, 32'h0000_0000, "ctrl reset");
        rd_chk(tmr_pkg::OFF_COUNT, 32'h0000_0000, "count reset");
        rd_chk(tmr_pkg::OFF_FLAGS, 32'h0000_0000, "flags reset");
        rd_chk(tmr_pkg::OFF_PIN, 32'h0000_0000, "state reset");
        check(32'(pin_oe), 32'h0000_0000, "pin driven at reset");
        rd_chk(8'h14, 32'h0000_0000, "unmapped read data");
        check(32'(slverr_seen), 32'h0000_0001, "unmapped no error");
    endtask

    task automatic t_normal;
        wr(tmr_pkg::OFF_CTRL, ctrl(3'h1, tmr_pkg::WGM_NORMAL, 2'h0, 1'b0));
        wr(tmr_pkg::OFF_COUNT, 32'h0000_00FE);
        tick(1);
        rd_chk(tmr_pkg::OFF_FLAGS, 32'h0000_0000, "early overflow");
        tick(1);
        rd_chk(tmr_pkg::OFF_COUNT, 32'h0000_0000, "no wrap");
        rd_chk(tmr_pkg::OFF_FLAGS, OVF, "overflow missing");
    endtask

    task automatic t_block;
        wr(tmr_pkg::OFF_COMPARE, 32'h0000_0010);
        wr(tmr_pkg::OFF_FLAGS, OVF | CMP);
        wr(tmr_pkg::OFF_COUNT, 32'h0000_0010);
        tick(2);
        rd_chk(tmr_pkg::OFF_FLAGS, 32'h0000_0000, "match not blocked");
        wr(tmr_pkg::OFF_CTRL, ctrl(3'h0, tmr_pkg::WGM_NORMAL, 2'h0, 1'b0));
        tick(3);
        rd_chk(tmr_pkg::OFF_COUNT, 32'h0000_0012, "counted while off");
        wr(tmr_pkg::OFF_CTRL, ctrl(3'h1, tmr_pkg::WGM_NORMAL, 2'h0, 1'b0));
        wr(tmr_pkg::OFF_COUNT, 32'h0000_000F);
        tick(2);
        rd_chk(tmr_pkg::OFF_FLAGS, 32'h0000_0000, "match flag early");
        tick(1);
        rd_chk(tmr_pkg::OFF_FLAGS, CMP, "match flag missing");
    endtask

    task automatic t_force_pin;
        wr(tmr_pkg::OFF_FLAGS, OVF | CMP);
        wr(tmr_pkg::OFF_CTRL,
           ctrl(3'h0, tmr_pkg::WGM_NORMAL, tmr_pkg::COM_SET, 1'b1));
        rd_chk(tmr_pkg::OFF_PIN, ST, "force did not set");
        rd_chk(tmr_pkg::OFF_FLAGS, 32'h0000_0000, "force set flag");
        rd_chk(tmr_pkg::OFF_COUNT, 32'h0000_0012, "force moved count");
        // Output state prepared before the driver is enabled
        wr(tmr_pkg::OFF_PIN, DIR);
        rd_chk(tmr_pkg::OFF_PIN, DIR | ST, "direction write");
        check(32'(pin_level), 32'h0000_0001, "pin not from state");
        wr(tmr_pkg::OFF_CTRL, ctrl(3'h1, tmr_pkg::WGM_FAST, 2'h0, 1'b0));
        rd_chk(tmr_pkg::OFF_PIN, DIR | ST, "state lost on mode");
        tick(256);
        rd_chk(tmr_pkg::OFF_COUNT, 32'h0000_0012, "fast period");
        rd_chk(tmr_pkg::OFF_PIN, DIR | ST, "mode zero acted");
        check(32'(pin_level), 32'h0000_0000, "pin not from port");
    endtask

    task automatic t_ctc;
        wr(tmr_pkg::OFF_CTRL,
           ctrl(3'h1, tmr_pkg::WGM_CLEAR, tmr_pkg::COM_TOGGLE, 1'b0));
        wr(tmr_pkg::OFF_COMPARE, 32'h0000_0003);
        wr(tmr_pkg::OFF_COUNT, 32'h0000_0000);
        tick(4);
        rd_chk(tmr_pkg::OFF_COUNT, 32'h0000_0000, "no clear at top");
        rd_chk(tmr_pkg::OFF_PIN, DIR, "no toggle");
        tick(4);
        rd_chk(tmr_pkg::OFF_PIN, DIR | ST, "no second toggle");
        check(32'(pin_level), 32'h0000_0001, "pin level toggle");
        tick(2);
        wr(tmr_pkg::OFF_COMPARE, 32'h0000_0001);
        wr(tmr_pkg::OFF_FLAGS, OVF | CMP);
        tick(254);
        rd_chk(tmr_pkg::OFF_COUNT, 32'h0000_0000, "missed top run");
        rd_chk(tmr_pkg::OFF_FLAGS, OVF, "overflow at wrap");
        tick(2);
        rd_chk(tmr_pkg::OFF_COUNT, 32'h0000_0000, "new top late");
    endtask

    task automatic t_fast;
        wr(tmr_pkg::OFF_CTRL,
           ctrl(3'h1, tmr_pkg::WGM_FAST, tmr_pkg::COM_CLEAR, 1'b0));
        wr(tmr_pkg::OFF_COUNT, 32'h0000_00FD);
        wr(tmr_pkg::OFF_COMPARE, 32'h0000_0080);
        wr(tmr_pkg::OFF_FLAGS, OVF | CMP);
        tick(2);
        // Match from the last clear-mode tick lands on the first tick here
        rd_chk(tmr_pkg::OFF_FLAGS, OVF | CMP, "overflow at max");
        tick(1);
        rd_chk(tmr_pkg::OFF_COUNT, 32'h0000_0000, "no wrap");
        rd_chk(tmr_pkg::OFF_PIN, DIR | ST, "not set at wrap");
        // Old compare 01 would have cleared the state by now
        tick(128);
        rd_chk(tmr_pkg::OFF_PIN, DIR | ST, "compare not reloaded");
        tick(1);
        rd_chk(tmr_pkg::OFF_PIN, DIR, "not cleared at match");
        wr(tmr_pkg::OFF_CTRL,
           ctrl(3'h1, tmr_pkg::WGM_FAST, tmr_pkg::COM_SET, 1'b0));
        tick(127);
        rd_chk(tmr_pkg::OFF_PIN, DIR, "not cleared at wrap");
        tick(129);
        rd_chk(tmr_pkg::OFF_PIN, DIR | ST, "not set at match");
        // Compare at max: reload at next wrap, then set and never cleared
        wr(tmr_pkg::OFF_COMPARE, 32'h0000_00FF);
        tick(511);
        rd_chk(tmr_pkg::OFF_PIN, DIR | ST, "not flat at max");
        wr(tmr_pkg::OFF_CTRL,
           ctrl(3'h1, tmr_pkg::WGM_FAST, tmr_pkg::COM_TOGGLE, 1'b0));
        tick(256);
        rd_chk(tmr_pkg::OFF_PIN, DIR, "no toggle in fast");
        rd_chk(tmr_pkg::OFF_COUNT, 32'h0000_0080, "count moved by mode");
    endtask

    // ****************************************************************
    // Main sequence and verdict
    // ****************************************************************
    task automatic results;
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        err_total  = 0;
        n_compared = 0;
        cycles     = 0;
        rst_n      = 1'b0;
        timer_tick = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0000_0000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_normal();
        t_block();
        t_force_pin();
        t_ctc();
        t_fast();
        results();
    end
endmodule
`default_nettype wire

// ===== sim/tmr_pin_load.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// External load on the compare output pin
// ****************************************************************
module tmr_pin_load
(
    input  wire logic pin_out,   // Value the block drives
    input  wire logic pin_oe,    // Driver enable, high drives
    output logic      pin_level  // Level seen on the wire
);
    // Weak pull-down on the board: an undriven pin reads low,
    // so a released pin never shows its last driven value
    always_comb
    begin
        pin_level = pin_oe ? pin_out : 1'b0;
    end
endmodule
`default_nettype wire

// ===== src/tmr_pkg.sv
// ****************************************************************
// Timer package
// ****************************************************************
package tmr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00; // Control
    localparam logic [7:0] OFF_COUNT   = 8'h04; // Timer count
    localparam logic [7:0] OFF_COMPARE = 8'h08; // Compare value
    localparam logic [7:0] OFF_FLAGS   = 8'h0C; // Flags
    localparam logic [7:0] OFF_PIN     = 8'h10; // Pin control
    // Control field positions
    localparam int CTRL_CS_LSB   = 0;  // Clock select, 3 bits
    localparam int CTRL_WGM_LSB  = 3;  // Waveform mode, 2 bits
    localparam int CTRL_COM_LSB  = 5;  // Compare output mode, 2 bits
    localparam int CTRL_FORCE    = 7;  // Force compare strobe
    // Flag positions
    localparam int FLAG_OVF      = 0;  // Overflow flag
    localparam int FLAG_CMP      = 1;  // Compare match flag
    // Pin control positions
    localparam int PIN_DIR       = 0;  // Compare pin direction bit
    localparam int PIN_PORT      = 1;  // Port data bit
    localparam int PIN_STATE     = 2;  // Output state, read only
    // Reset values and counter extremes
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CNT_MAX  = 8'hFF;
    localparam logic [7:0] CNT_BOT  = 8'h00;
    // Waveform modes
    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PHASE  = 2'h1;
    localparam logic [1:0] WGM_CLEAR  = 2'h2;
    localparam logic [1:0] WGM_FAST   = 2'h3;
    // Compare output modes
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;
endpackage

// ===== src/tmr_waveform_gen.sv
`timescale 1ns/1ns
`default_nettype none
module tmr_waveform_gen
(
    input  wire logic        clk,        // System clock, 20 MHz
    input  wire logic        rst_n,      // Synchronous reset
    input  wire logic        timer_tick, // Tick enable from prescaler
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB enable
    input  wire logic        pwrite,     // APB direction
    input  wire logic [7:0]  paddr,      // APB byte address
    input  wire logic [31:0] pwdata,     // APB write data
    output logic      [31:0] prdata,     // APB read data
    output logic             pready,     // APB ready
    output logic             pslverr,    // APB error
    output logic             pin_out,    // Pin output value
    output logic             pin_oe      // Pin output enable
);
    // ************************************************************
    // Register state
    // ************************************************************
    logic [2:0] clock_select_q;         // Zero stops the counter
    logic [1:0] waveform_mode_q;        // Counting sequence
    logic [1:0] compare_output_mode_q;  // Output action
    logic [7:0] timer_count_q;          // Counter
    logic [7:0] compare_buf_q;          // Software-written compare
    logic [7:0] compare_value_q;        // Active compare
    logic       overflow_flag_q;        // Sticky overflow
    logic       compare_match_flag_q;   // Sticky match
    logic       match_pend_q;           // Match seen, flag next tick
    logic       block_q;                // Block match next tick
    logic       compare_output_state_q; // Internal output state
    logic       dir_q;                  // Pin direction bit
    logic       port_q;                 // Port data bit
    logic [31:0] prdata_q;              // Registered read data

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic access;      // Access phase
    logic wr;          // Write accepted this cycle
    logic hit;         // Mapped address
    logic wr_ctrl;     // Control write
    logic wr_count;    // Count write
    logic wr_cmp;      // Compare write
    logic wr_flags;    // Flags write
    logic wr_pin;      // Pin control write
    logic force_cmp;   // Force strobe accepted
    logic run_tick;    // Counter advances this cycle
    logic is_pwm;      // Buffered compare modes
    logic raw_match;   // Comparator equality
    logic match;       // Match after blocking
    logic at_max;      // Counter at maximum
    logic wrap;        // Counter passes max to zero this tick

    assign access    = psel && penable;
    assign wr        = access && pwrite;
    assign hit       = (paddr == tmr_pkg::OFF_CTRL)
                    || (paddr == tmr_pkg::OFF_COUNT)
                    || (paddr == tmr_pkg::OFF_COMPARE)
                    || (paddr == tmr_pkg::OFF_FLAGS)
                    || (paddr == tmr_pkg::OFF_PIN);
    assign wr_ctrl   = wr && (paddr == tmr_pkg::OFF_CTRL);
    assign wr_count  = wr && (paddr == tmr_pkg::OFF_COUNT);
    assign wr_cmp    = wr && (paddr == tmr_pkg::OFF_COMPARE);
    assign wr_flags  = wr && (paddr == tmr_pkg::OFF_FLAGS);
    assign wr_pin    = wr && (paddr == tmr_pkg::OFF_PIN);
    // Zero-wait slave, error on unmapped addresses
    assign pready    = 1'b1;
    assign pslverr   = access && !hit;
    assign prdata    = prdata_q;

    // ************************************************************
    // Compare and tick qualification
    // ************************************************************
    // Phase-correct is out of scope but buffered like a PWM mode
    assign is_pwm    = waveform_mode_q[0];
    // Tick only moves the counter with a clock source selected
    assign run_tick  = timer_tick && (clock_select_q != 3'h0);
    assign raw_match = (timer_count_q == compare_value_q);
    // Matches are judged on ticks; a count write blanks one tick
    assign match     = run_tick && raw_match && !block_q;
    assign at_max    = (timer_count_q == tmr_pkg::CNT_MAX);
    assign wrap      = run_tick && at_max && !wr_count;
    // Force only in non-PWM modes, using the output mode written with it
    assign force_cmp = wr_ctrl && pwdata[tmr_pkg::CTRL_FORCE]
                    && !pwdata[tmr_pkg::CTRL_WGM_LSB];

    // Applies an output mode action to the output state
    function automatic logic apply_action
    (
        input logic [1:0] com,
        input logic       cur
    );
        logic r;
        r = cur;
        unique case (com)
            tmr_pkg::COM_OFF:    r = cur;  // No action
            tmr_pkg::COM_TOGGLE: r = !cur; // Toggle
            tmr_pkg::COM_CLEAR:  r = 1'b0; // Clear
            tmr_pkg::COM_SET:    r = 1'b1; // Set
        endcase
        return r;
    endfunction

    // ************************************************************
    // Control registers
    // ************************************************************
    // Output mode is never buffered: it acts on the next match
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            clock_select_q        <= 3'h0;
            waveform_mode_q       <= 2'h0;
            compare_output_mode_q <= 2'h0;
        end
        else if (wr_ctrl)
        begin
            clock_select_q        <= pwdata[tmr_pkg::CTRL_CS_LSB +: 3];
            waveform_mode_q       <= pwdata[tmr_pkg::CTRL_WGM_LSB +: 2];
            compare_output_mode_q <= pwdata[tmr_pkg::CTRL_COM_LSB +: 2];
        end
    end

    // Pin direction and port data
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dir_q  <= 1'b0;
            port_q <= 1'b0;
        end
        else if (wr_pin)
        begin
            dir_q  <= pwdata[tmr_pkg::PIN_DIR];
            port_q <= pwdata[tmr_pkg::PIN_PORT];
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    // Sequence depends only on the waveform mode and the compare value
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            timer_count_q <= tmr_pkg::RST_BYTE;
        else if (wr_count)
            // Software write beats any clear or count
            timer_count_q <= pwdata[7:0];
        else if (run_tick)
        begin
            if (waveform_mode_q == tmr_pkg::WGM_CLEAR && match)
                timer_count_q <= tmr_pkg::CNT_BOT;
            else
                // Wraps past max in all four modes
                timer_count_q <= timer_count_q + 8'h01;
        end
    end

    // One-tick match blanking after a count write, even when stopped
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            block_q <= 1'b0;
        else if (wr_count)
            block_q <= 1'b1;
        else if (run_tick)
            block_q <= 1'b0;
    end

    // ************************************************************
    // Compare value and its buffer
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            compare_buf_q <= tmr_pkg::RST_BYTE;
        else if (wr_cmp)
            compare_buf_q <= pwdata[7:0];
    end

    // Direct in non-PWM modes; reloaded at the wrap in PWM modes,
    // which keeps pulses whole at the cost of a period of latency
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            compare_value_q <= tmr_pkg::RST_BYTE;
        else if (!is_pwm && wr_cmp)
            compare_value_q <= pwdata[7:0];
        else if (is_pwm && wrap)
            compare_value_q <= compare_buf_q;
    end

    // ************************************************************
    // Flags
    // ************************************************************
    // Overflow: max to zero in modes 0 and 2, at max in fast PWM
    logic ovf_set;
    assign ovf_set = (waveform_mode_q == tmr_pkg::WGM_FAST)
        ? (run_tick && (timer_count_q == 8'hFE) && !wr_count)
        : (wrap && !waveform_mode_q[0]);

    // Set wins over a same-cycle software clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            overflow_flag_q <= 1'b0;
        else if (ovf_set)
            overflow_flag_q <= 1'b1;
        else if (wr_flags && pwdata[tmr_pkg::FLAG_OVF])
            overflow_flag_q <= 1'b0;
    end

    // Match is remembered, flag rises on the following tick
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            match_pend_q <= 1'b0;
        else if (run_tick)
            match_pend_q <= match;
    end

    // Force never reaches this flag
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            compare_match_flag_q <= 1'b0;
        else if (run_tick && match_pend_q)
            compare_match_flag_q <= 1'b1;
        else if (wr_flags && pwdata[tmr_pkg::FLAG_CMP])
            compare_match_flag_q <= 1'b0;
    end

    // ************************************************************
    // Waveform generator
    // ************************************************************
    // Not touched by mode writes; only matches, wraps and force move it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            compare_output_state_q <= 1'b0;
        else if (force_cmp)
            compare_output_state_q <= apply_action(
                pwdata[tmr_pkg::CTRL_COM_LSB +: 2],
                compare_output_state_q);
        else if (waveform_mode_q == tmr_pkg::WGM_FAST)
        begin
            // Match wins at max so compare at max gives a flat level
            if (match && compare_output_mode_q[1])
                compare_output_state_q <= compare_output_mode_q[0];
            else if (match && compare_output_mode_q == tmr_pkg::COM_TOGGLE)
                compare_output_state_q <= !compare_output_state_q;
            else if (wrap && compare_output_mode_q[1])
                compare_output_state_q <= !compare_output_mode_q[0];
        end
        else if (match && !waveform_mode_q[0])
            // Mode zero keeps the state unchanged
            compare_output_state_q <= apply_action(
                compare_output_mode_q,
                compare_output_state_q);
    end

    // Pin source switches whenever any output mode bit is set
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end
        else
        begin
            pin_out <= (compare_output_mode_q != tmr_pkg::COM_OFF)
                     ? compare_output_state_q : port_q;
            pin_oe  <= dir_q;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    // Captured in setup so it stands through the access phase
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prdata_q <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            unique case (paddr)
                tmr_pkg::OFF_CTRL:    prdata_q <= {24'h000000, 1'b0,
                    compare_output_mode_q, waveform_mode_q,
                    clock_select_q};
                tmr_pkg::OFF_COUNT:   prdata_q <= {24'h000000, timer_count_q};
                tmr_pkg::OFF_COMPARE: prdata_q <= {24'h000000, compare_buf_q};
                tmr_pkg::OFF_FLAGS:   prdata_q <= {30'h00000000,
                    compare_match_flag_q, overflow_flag_q};
                tmr_pkg::OFF_PIN:     prdata_q <= {29'h00000000,
                    compare_output_state_q, port_q, dir_q};
                default:              prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Helper: a count write not yet followed by a tick
    logic chk_wr_q;
    // Helper: the last tick carried a match
    logic chk_hit_q;

    // Kept apart from the blanking flop so a broken blank still shows
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            chk_wr_q <= 1'b0;
        else if (wr_count)
            chk_wr_q <= 1'b1;
        else if (run_tick)
            chk_wr_q <= 1'b0;
    end

    // Remembers a match until the next tick, however far away
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            chk_hit_q <= 1'b0;
        else if (run_tick)
            chk_hit_q <= match;
    end

    sequence cnt_wr_s;
        wr_count;
    endsequence

    sequence blank_tick_s;
        run_tick && chk_wr_q;
    endsequence

    sequence late_tick_s;
        run_tick && chk_hit_q;
    endsequence

    reset_state_a: assert property (@(posedge clk)
        !rst_n |=> !compare_output_state_q)
        else $error("output state not cleared by reset");

    write_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_wr_s |=> timer_count_q == $past(pwdata[7:0]))
        else $error("count write lost");

    block_match_a: assert property (@(posedge clk) disable iff (!rst_n)
        blank_tick_s |-> !match)
        else $error("match not blocked after count write");

    stop_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clock_select_q == 3'h0 && !wr_count)
        |=> timer_count_q == $past(timer_count_q))
        else $error("counter moved while stopped");

    clear_match_a: assert property (@(posedge clk) disable iff (!rst_n)
        (waveform_mode_q == tmr_pkg::WGM_CLEAR && match && !wr_count)
        |=> timer_count_q == tmr_pkg::CNT_BOT)
        else $error("counter not cleared on match");

    flag_late_a: assert property (@(posedge clk) disable iff (!rst_n)
        late_tick_s |=> compare_match_flag_q)
        else $error("match flag not set one tick later");

    com_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (compare_output_mode_q == tmr_pkg::COM_OFF && !force_cmp)
        |=> $stable(compare_output_state_q))
        else $error("output state moved with mode zero");

    pin_mux_a: assert property (@(posedge clk) disable iff (!rst_n)
        (compare_output_mode_q != tmr_pkg::COM_OFF && !wr_ctrl)
        |=> pin_out == $past(compare_output_state_q))
        else $error("pin not driven from output state");

    ovf_normal_a: assert property (@(posedge clk) disable iff (!rst_n)
        (waveform_mode_q == tmr_pkg::WGM_NORMAL && wrap)
        |=> overflow_flag_q && timer_count_q == tmr_pkg::CNT_BOT)
        else $error("overflow not set at wrap");
endmodule
`default_nettype wire
